// ### dtic_pkg.sv
// dtic_pkg: register map, field layout and constants for the dual timer and cpu interrupt control block
// assumes a plain address/strobe register port with 24-bit byte addresses and 16-bit data
package dtic_pkg;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_SRC = 6;
  // write offsets of the reload registers
  localparam logic [23:0] OFS_T1_PRE_WR = 24'hF10000;
  localparam logic [23:0] OFS_T1_DIV_WR = 24'hF10002;
  localparam logic [23:0] OFS_T2_PRE_WR = 24'hF10004;
  localparam logic [23:0] OFS_T2_DIV_WR = 24'hF10006;
  // read offsets of the live counters
  localparam logic [23:0] OFS_T1_PRE_RD = 24'hF10036;
  localparam logic [23:0] OFS_T1_DIV_RD = 24'hF10038;
  localparam logic [23:0] OFS_T2_PRE_RD = 24'hF1003A;
  localparam logic [23:0] OFS_T2_DIV_RD = 24'hF1003C;
  // cpu interrupt control (write enables/clears, read pending)
  localparam logic [23:0] OFS_IRQ_CTRL  = 24'hF10020;
  // dsp-side timer interrupt mask, status and the dsp interrupt port
  localparam logic [23:0] OFS_DSP_MASK  = 24'hF10040;
  localparam logic [23:0] OFS_DSP_STAT  = 24'hF10042;
  localparam logic [23:0] OFS_DSP_PORT  = 24'hF10044;
  // field positions in the control register
  localparam int unsigned BIT_EXT   = 0;
  localparam int unsigned BIT_DSP   = 1;
  localparam int unsigned BIT_TIM1  = 2;
  localparam int unsigned BIT_TIM2  = 3;
  localparam int unsigned BIT_ASYN  = 4;
  localparam int unsigned BIT_SYN   = 5;
  localparam int unsigned CLR_SHIFT = 8;
  // reset values
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [5:0]  RST_ENA    = 6'h00;
  localparam logic [1:0]  RST_DMASK  = 2'h0;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } dtic_bus_s;

  typedef struct packed {
    logic [15:0] pre_load;
    logic [15:0] div_load;
    logic [15:0] pre_cnt;
    logic [15:0] div_cnt;
  } dtic_timer_s;
endpackage

// ### dtic_top.sv
// dtic_top: two cascaded prescaler/divider timers and the cpu interrupt control register
// assumes bus strobes come from logic on i_clk_sys; irq pins from outside are synchronised here
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

// Register map: 24-bit byte addresses, 16-bit data words
//   timer one prescale reload  write F10000, live count read F10036
//   timer one divider reload   write F10002, live count read F10038
//   timer two prescale reload  write F10004, live count read F1003A
//   timer two divider reload   write F10006, live count read F1003C
//   cpu irq control  write F10020: enables in [5:0], clears in [13:8]
//   cpu irq control  read  F10020: pending flags in [5:0], zero above
//   dsp timer mask   write/read F10040: bit 0 timer one, bit 1 timer two
//   dsp timer status read F10042: sticky, the read itself clears it
//   dsp irq port     dsp write F10044: raises the dsp source of the cpu irq
//   reload addresses read back zero; other unmapped reads give zero
//   unmapped writes are dropped without any side effect
//
// Bus timing
//   a write takes hold at the edge that sees the write strobe
//   read data stand only in the cycle after the read strobe, zero otherwise
//   a live count read shows the counter as it stood at the strobe edge
//   strobes may come back to back; nothing ever waits
//
// Timer walk, prescale reload 1 and divider reload 1 written at edge c0
//   c1  prescaler 1, divider 1
//   c2  prescaler 0: one prescale pulse
//   c3  prescaler 1, divider 0
//   c4  prescaler 0 with divider 0: timer event, both stages reload
//   c5  pending flag set, cpu irq high when enabled
//   the period is (n + 1) * (m + 1) clocks, one at the smallest
//   a reload write presets its stage at once, so it doubles as a one-shot delay
//   rewriting one stage does not disturb the other stage
//
// Interrupt timing
//   a pending flag sets at the first edge that sees its event
//   irq outputs use next flags, enables and mask, so they never lag a write
//   a clear loses to a new event of its own source in the same cycle
//   dsp status loses a read clear to a timer event in the same way
//   external pin: three edges from its rise to the pending flag
//   serial requests are levels and set their flag every cycle while high
//   a clear of a serial source only sticks once its request has dropped
//
// Reset state
//   reloads and counters are zero, so both timers fire on every clock
//   timer flags therefore set at once; clear them before enabling a timer
//   enables and dsp mask are zero, so both irq outputs stay low
//
// Limitations
//   every control write rewrites all six enables; keep a software copy
//   bits 6, 7, 14 and 15 of a control write are not stored
//   counts are not frozen for a read; two reads may straddle a reload
//   only the rising edge of the external pin counts; a held level does not
//   irq pins pass two flops, trading two clocks of latency for safety

// Summary of operation
// - two identical timers, each a 16-bit prescaler then a 16-bit divider
// - prescaler divides the clock by its written value plus one
// - prescaler counts down, reloads on write and on reaching zero
// - divider divides prescaler pulses by its written value plus one
// - divider counts down, reloads on write and at zero; write presets delay
// - divider zero raises dsp and cpu timer interrupts, masked separately
// - live counters readable at addresses distinct from reload write addresses
// - six cpu sources: external, dsp, timer one, timer two, async, sync serial
// - external request taken on a rising edge of the external input only
// - a dsp write to its interrupt port raises the dsp cpu interrupt
// - control bits 0 to 5 written set the six source enables
// - control bits 0 to 5 read return the six pending flags
// - writing one to control bits 8 to 13 clears the matching pending flag
module dtic_top (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic [23:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_dsp_wr,
  input  wire logic        i_external_irq_input,
  input  wire logic        i_async_serial_irq,
  input  wire logic        i_sync_serial_irq,
  output logic      [15:0] o_rdata,
  output logic             o_cpu_irq,
  output logic             o_dsp_irq
);

  dtic_pkg::dtic_bus_s   bus;
  dtic_pkg::dtic_timer_s tmr [2];
  logic [1:0]  pre_zero;
  logic [1:0]  div_zero;
  logic [1:0]  pre_wr;
  logic [1:0]  div_wr;
  logic [2:0]  ext_sync_r;
  logic [1:0]  asyn_sync_r;
  logic [1:0]  syn_sync_r;
  logic [5:0]  ena_r;
  logic [5:0]  pend_r;
  logic [5:0]  pend_nxt;
  logic [5:0]  event_set;
  logic [5:0]  clr_bits;
  logic [1:0]  dmask_r;
  logic [1:0]  dstat_r;
  logic [1:0]  dstat_nxt;
  logic        dsp_port_hit;
  logic        ctrl_wr;
  logic [15:0] rdata_nxt;
  logic [5:0]  ena_nxt;
  logic [1:0]  dmask_nxt;
  logic        sel_t1_pre;
  logic        sel_t1_div;
  logic        sel_t2_pre;
  logic        sel_t2_div;
  logic        sel_ctrl;
  logic        sel_dmask;
  logic        sel_dstat;

  // single address match, reused by every decoder below
  function automatic logic hit(input logic [23:0] a, input logic [23:0] ofs);
    hit = (a == ofs);
  endfunction

  assign bus.addr  = i_addr;
  assign bus.wdata = i_wdata;
  assign bus.wr    = i_wr;
  assign bus.rd    = i_rd;

  // reload write strobes per timer
  assign pre_wr[0] = bus.wr && hit(bus.addr, dtic_pkg::OFS_T1_PRE_WR);
  assign div_wr[0] = bus.wr && hit(bus.addr, dtic_pkg::OFS_T1_DIV_WR);
  assign pre_wr[1] = bus.wr && hit(bus.addr, dtic_pkg::OFS_T2_PRE_WR);
  assign div_wr[1] = bus.wr && hit(bus.addr, dtic_pkg::OFS_T2_DIV_WR);

  // the two timers share one structure; a generate keeps them identical
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      assign pre_zero[g] = (tmr[g].pre_cnt == 16'h0000);
      assign div_zero[g] = (tmr[g].div_cnt == 16'h0000) && pre_zero[g];

      // reload values kept so zero-reload repeats the programmed period
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          tmr[g].pre_load <= dtic_pkg::RST_RELOAD;
        end else if (pre_wr[g]) begin
          tmr[g].pre_load <= bus.wdata;
        end
      end

      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          tmr[g].div_load <= dtic_pkg::RST_RELOAD;
        end else if (div_wr[g]) begin
          tmr[g].div_load <= bus.wdata;
        end
      end

      // prescaler: n+1 clocks per output pulse
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          tmr[g].pre_cnt <= dtic_pkg::RST_RELOAD;
        end else if (pre_wr[g]) begin
          tmr[g].pre_cnt <= bus.wdata;
        end else if (pre_zero[g]) begin
          tmr[g].pre_cnt <= tmr[g].pre_load;
        end else begin
          tmr[g].pre_cnt <= tmr[g].pre_cnt - 16'h0001;
        end
      end

      // divider steps only on a prescaler pulse: m+1 pulses per event
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          tmr[g].div_cnt <= dtic_pkg::RST_RELOAD;
        end else if (div_wr[g]) begin
          tmr[g].div_cnt <= bus.wdata;
        end else if (pre_zero[g]) begin
          if (tmr[g].div_cnt == 16'h0000) begin
            tmr[g].div_cnt <= tmr[g].div_load;
          end else begin
            tmr[g].div_cnt <= tmr[g].div_cnt - 16'h0001;
          end
        end
      end
    end
  endgenerate

  // external pin: two sync flops, a third only keeps the old level for the edge
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ext_sync_r <= 3'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], i_external_irq_input};
    end
  end

  // async serial request pin, two sync flops
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      asyn_sync_r <= 2'h0;
    end else begin
      asyn_sync_r <= {asyn_sync_r[0], i_async_serial_irq};
    end
  end

  // sync serial request pin, two sync flops
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      syn_sync_r <= 2'h0;
    end else begin
      syn_sync_r <= {syn_sync_r[0], i_sync_serial_irq};
    end
  end

  assign dsp_port_hit = i_dsp_wr && hit(bus.addr, dtic_pkg::OFS_DSP_PORT);
  assign ctrl_wr      = bus.wr && hit(bus.addr, dtic_pkg::OFS_IRQ_CTRL);

  // source events in enable bit order
  always_comb begin
    event_set = 6'h00;
    event_set[dtic_pkg::BIT_EXT]  = ext_sync_r[1] && !ext_sync_r[2];
    event_set[dtic_pkg::BIT_DSP]  = dsp_port_hit;
    event_set[dtic_pkg::BIT_TIM1] = div_zero[0];
    event_set[dtic_pkg::BIT_TIM2] = div_zero[1];
    event_set[dtic_pkg::BIT_ASYN] = asyn_sync_r[1];
    event_set[dtic_pkg::BIT_SYN]  = syn_sync_r[1];
  end

  // clear bits sit 8 above their enable; reserved 6, 7 are not stored
  assign clr_bits = ctrl_wr ? bus.wdata[dtic_pkg::CLR_SHIFT +: 6] : 6'h00;

  // next enables, shared by the enable flops and the cpu irq output
  always_comb begin
    ena_nxt = ena_r;
    if (ctrl_wr) begin
      ena_nxt = bus.wdata[5:0];
    end
  end

  // enables are written wholesale with each control write
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ena_r <= dtic_pkg::RST_ENA;
    end else begin
      ena_r <= ena_nxt;
    end
  end

  // sticky pending: a new event beats a clear in the same cycle
  always_comb begin
    pend_nxt = (pend_r & ~clr_bits) | event_set;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pend_r <= 6'h00;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // next dsp mask, shared by the mask flops and the dsp irq output
  always_comb begin
    dmask_nxt = dmask_r;
    if (bus.wr && hit(bus.addr, dtic_pkg::OFS_DSP_MASK)) begin
      dmask_nxt = bus.wdata[1:0];
    end
  end

  // dsp-side timer path: own mask, sticky status cleared by reading it
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      dmask_r <= dtic_pkg::RST_DMASK;
    end else begin
      dmask_r <= dmask_nxt;
    end
  end

  always_comb begin
    dstat_nxt = dstat_r;
    if (bus.rd && sel_dstat) begin
      dstat_nxt = 2'h0;
    end
    dstat_nxt = dstat_nxt | div_zero;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      dstat_r <= 2'h0;
    end else begin
      dstat_r <= dstat_nxt;
    end
  end

  // cpu irq registered from next flags and next enables so it never lags a write
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_cpu_irq <= 1'b0;
    end else begin
      o_cpu_irq <= |(pend_nxt & ena_nxt);
    end
  end

  // dsp irq uses the next mask too, so clearing the mask drops it at that edge
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_dsp_irq <= 1'b0;
    end else begin
      o_dsp_irq <= |(dstat_nxt & dmask_nxt);
    end
  end

  // read address decode, one select per readable register
  assign sel_t1_pre = hit(bus.addr, dtic_pkg::OFS_T1_PRE_RD);
  assign sel_t1_div = hit(bus.addr, dtic_pkg::OFS_T1_DIV_RD);
  assign sel_t2_pre = hit(bus.addr, dtic_pkg::OFS_T2_PRE_RD);
  assign sel_t2_div = hit(bus.addr, dtic_pkg::OFS_T2_DIV_RD);
  assign sel_ctrl   = hit(bus.addr, dtic_pkg::OFS_IRQ_CTRL);
  assign sel_dmask  = hit(bus.addr, dtic_pkg::OFS_DSP_MASK);
  assign sel_dstat  = hit(bus.addr, dtic_pkg::OFS_DSP_STAT);

  // read mux; counters read live at their own addresses, unmapped reads zero
  always_comb begin
    rdata_nxt = 16'h0000;
    case (1'b1)
      sel_t1_pre: rdata_nxt = tmr[0].pre_cnt;
      sel_t1_div: rdata_nxt = tmr[0].div_cnt;
      sel_t2_pre: rdata_nxt = tmr[1].pre_cnt;
      sel_t2_div: rdata_nxt = tmr[1].div_cnt;
      sel_ctrl:   rdata_nxt = {10'h000, pend_r};
      sel_dmask:  rdata_nxt = {14'h0000, dmask_r};
      sel_dstat:  rdata_nxt = {14'h0000, dstat_r};
      default:    rdata_nxt = 16'h0000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rdata <= 16'h0000;
    end else if (bus.rd) begin
      o_rdata <= rdata_nxt;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule

// ### dtic_top_asserts.sv
// dtic_top_asserts: port-level checks of the timer and cpu interrupt block
// assumes the single clock and synchronous active-high reset of dtic_top
`timescale 1ns/1ps
module dtic_chk (
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_dsp_wr,
  input wire logic        i_external_irq_input,
  input wire logic [15:0] o_rdata,
  input wire logic        o_cpu_irq,
  input wire logic        o_dsp_irq
);
  logic [5:0] en_r;
  logic [1:0] dm_r;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // shadow the write-only enables and the dsp mask so irq levels can be tied to them
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      en_r <= 6'h00;
      dm_r <= 2'h0;
    end else begin
      if (i_wr && i_addr == dtic_pkg::OFS_IRQ_CTRL) en_r <= i_wdata[5:0];
      if (i_wr && i_addr == dtic_pkg::OFS_DSP_MASK) dm_r <= i_wdata[1:0];
    end
  end
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data not idle");
  wo_rd_a: assert property ($past(i_rd) && $past(i_addr[23:4]) == 20'hF1000 |-> o_rdata == 16'h0000)
    else $error("reload address read not zero");
  ctrl_rd_a: assert property ($past(i_rd && i_addr == dtic_pkg::OFS_IRQ_CTRL) |-> o_rdata[15:6] == 10'h000)
    else $error("control read upper bits set");
  stat_rd_a: assert property ($past(i_rd && i_addr == dtic_pkg::OFS_DSP_STAT) |-> o_rdata[15:2] == 14'h0000)
    else $error("dsp status upper bits set");
  irq_en_a: assert property (o_cpu_irq |-> en_r != 6'h00) else $error("cpu irq with no enable");
  dsp_mask_a: assert property (o_dsp_irq |-> dm_r != 2'h0) else $error("dsp irq while masked");
  ext_edge_a: assert property ($rose(i_external_irq_input) && en_r[0] && !i_wr |-> ##[2:5] o_cpu_irq)
    else $error("external edge lost");
  dsp_port_a: assert property (i_dsp_wr && i_addr == dtic_pkg::OFS_DSP_PORT && en_r[1] |-> ##[1:2] o_cpu_irq)
    else $error("dsp port write lost");
  cover property ($rose(o_cpu_irq));
  cover property ($rose(o_dsp_irq));
  cover property ($past(i_rd && i_addr == dtic_pkg::OFS_IRQ_CTRL) && o_rdata != 16'h0000);
endmodule
bind dtic_top dtic_chk u_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_dsp_wr(i_dsp_wr), .i_external_irq_input(i_external_irq_input),
  .o_rdata(o_rdata), .o_cpu_irq(o_cpu_irq), .o_dsp_irq(o_dsp_irq));

// ### dtic_host.sv
// dtic_host: cpu and dsp bus master facing the register port
// assumes read data stand only in the cycle after the read strobe
`timescale 1ns/1ps
module dtic_host (
  input  wire logic           i_clk_sys,
  input  wire logic [15:0]    i_rdata,
  output dtic_pkg::dtic_bus_s o_bus,
  output logic                o_dsp_wr
);
  initial begin
    o_bus = '0;
    o_dsp_wr = 1'b0;
  end
  // one-cycle write; reserved control bits always sent as zero
  task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic dsp);
    @(posedge i_clk_sys);
    o_bus <= '{a, d & ((a == dtic_pkg::OFS_IRQ_CTRL) ? 16'h3F3F : 16'hFFFF), !dsp, 1'b0};
    o_dsp_wr <= dsp;
    @(posedge i_clk_sys);
    o_bus.wr <= 1'b0;
    o_dsp_wr <= 1'b0;
  endtask
  // one-cycle read; data taken mid-cycle so no edge race
  task automatic rd(input logic [23:0] a, output logic [15:0] q);
    @(posedge i_clk_sys);
    o_bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge i_clk_sys);
    o_bus.rd <= 1'b0;
    @(negedge i_clk_sys);
    q = i_rdata;
  endtask
endmodule

// ### dtic_bench.sv
// dtic_bench: self-checking bench for the dual timer and cpu interrupt block
// assumes dtic_host drives the register port and the bench drives the irq pins
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t %0h %0h", $time, g, e); end end
module dtic_bench;
  logic clk = 1'b0, srst = 1'b1, ext = 1'b0, asy = 1'b0, syn = 1'b0;
  logic dsp_wr, cpu_irq, dsp_irq;
  logic [15:0] rdata, q;
  dtic_pkg::dtic_bus_s bus;
  int errors = 0, num_checks = 0, n, m, t;
  always #12.5 clk = ~clk;
  dtic_host host (.i_clk_sys(clk), .i_rdata(rdata), .o_bus(bus), .o_dsp_wr(dsp_wr));
  dtic_top dut (.i_clk_sys(clk), .i_srst(srst), .i_addr(bus.addr), .i_wdata(bus.wdata), .i_wr(bus.wr),
    .i_rd(bus.rd), .i_dsp_wr(dsp_wr), .i_external_irq_input(ext), .i_async_serial_irq(asy),
    .i_sync_serial_irq(syn), .o_rdata(rdata), .o_cpu_irq(cpu_irq), .o_dsp_irq(dsp_irq));
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // count negedges until the cpu irq rises, bounded
  task automatic wait_irq(output int c);
    c = 0;
    @(negedge clk);
    while (cpu_irq !== 1'b1 && c < 200) begin
      @(negedge clk);
      c++;
    end
  endtask
  // watchdog: the tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end
  initial begin
    void'($urandom(29));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // a reload write presets the live counters
    n = 100 + $urandom % 900;
    m = $urandom % 50;
    host.wr(dtic_pkg::OFS_T1_PRE_WR, 16'(n), 1'b0);
    host.rd(dtic_pkg::OFS_T1_PRE_RD, q); `CHK(q, 16'(n - 1))
    host.wr(dtic_pkg::OFS_T1_DIV_WR, 16'(m), 1'b0);
    host.rd(dtic_pkg::OFS_T1_DIV_RD, q); `CHK(q, 16'(m))
    host.rd(dtic_pkg::OFS_T1_PRE_WR, q); `CHK(q, 16'h0000)
    host.rd(24'hF1000E, q); `CHK(q, 16'h0000)
    // timer two period measured rise to rise, pending cleared between
    n = 1 + $urandom % 3;
    m = 1 + $urandom % 3;
    host.wr(dtic_pkg::OFS_T2_PRE_WR, 16'(n), 1'b0);
    host.wr(dtic_pkg::OFS_T2_DIV_WR, 16'(m), 1'b0);
    host.wr(dtic_pkg::OFS_IRQ_CTRL, 16'h3F08, 1'b0);
    wait_irq(t);
    host.wr(dtic_pkg::OFS_IRQ_CTRL, 16'h3F08, 1'b0);
    wait_irq(t); `CHK(t, (n + 1) * (m + 1) - 2)
    host.rd(dtic_pkg::OFS_IRQ_CTRL, q); `CHK(q[3], 1'b1)
    // timer one measured the same way; must match the twin timer's rule
    n = 1 + $urandom % 3;
    m = 1 + $urandom % 3;
    host.wr(dtic_pkg::OFS_T1_PRE_WR, 16'(n), 1'b0);
    host.wr(dtic_pkg::OFS_T1_DIV_WR, 16'(m), 1'b0);
    host.wr(dtic_pkg::OFS_IRQ_CTRL, 16'h3F04, 1'b0);
    wait_irq(t);
    host.wr(dtic_pkg::OFS_IRQ_CTRL, 16'h3F04, 1'b0);
    wait_irq(t); `CHK(t, (n + 1) * (m + 1) - 2)
    for (int i = 0; i < 4; i++) host.wr(24'hF10000 + 24'(2 * i), 16'hFFFF, 1'b0);
    // each source alone: clear all, enable one, raise it
    for (int s = 0; s < 6; s++) begin
      host.wr(dtic_pkg::OFS_IRQ_CTRL, 16'h3F00 | (16'h0001 << s), 1'b0);
      @(negedge clk); `CHK(cpu_irq, 1'b0)
      @(posedge clk) {syn, asy, ext} <= {s == 5, s == 4, s == 0};
      if (s == 1) host.wr(dtic_pkg::OFS_DSP_PORT, 16'h0000, 1'b1);
      if (s == 2 || s == 3) host.wr(24'hF10000 + 24'(4 * (s - 2)), 16'h0000, 1'b0);
      if (s == 2 || s == 3) host.wr(24'hF10002 + 24'(4 * (s - 2)), 16'h0000, 1'b0);
      repeat (6) @(negedge clk); `CHK(cpu_irq, 1'b1)
      host.rd(dtic_pkg::OFS_IRQ_CTRL, q); `CHK(q[s], 1'b1)
      if (s == 0) begin
        host.wr(dtic_pkg::OFS_IRQ_CTRL, 16'h0101, 1'b0);
        repeat (6) @(negedge clk); `CHK(cpu_irq, 1'b0)
      end
      @(posedge clk) {syn, asy, ext} <= 3'b000;
    end
    // both timers now fire each clock: dsp path with its own mask
    host.wr(dtic_pkg::OFS_DSP_MASK, 16'h0001, 1'b0);
    repeat (3) @(negedge clk); `CHK(dsp_irq, 1'b1)
    host.rd(dtic_pkg::OFS_DSP_STAT, q); `CHK(q[0], 1'b1)
    host.wr(dtic_pkg::OFS_DSP_MASK, 16'h0000, 1'b0);
    repeat (3) @(negedge clk); `CHK(dsp_irq, 1'b0)
    host.wr(dtic_pkg::OFS_IRQ_CTRL, 16'h3F00, 1'b0);
    repeat (2) @(negedge clk); `CHK(cpu_irq, 1'b0)
    stop_test();
  end
endmodule
